// ===== design/dahp_pkg.sv
// shared constants and types of the dual converter serial host port
package dahp_pkg;

	// timing
	localparam int CLK_FREQ_MHZ    = 100;
	localparam int CONV_TIME_NS    = 500;
	localparam int CONV_CYC        = (CONV_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
	localparam int STBY_WAKE_US    = 10;
	localparam int STBY_WAKE_CYC   = STBY_WAKE_US * CLK_FREQ_MHZ;
	localparam int PD_WAKE_EXT_MS  = 1;
	localparam int PD_WAKE_INT_MS  = 3;
	localparam int PD_WAKE_EXT_CYC = PD_WAKE_EXT_MS * 1000 * CLK_FREQ_MHZ;
	localparam int PD_WAKE_INT_CYC = PD_WAKE_INT_MS * 1000 * CLK_FREQ_MHZ;
	localparam int WAKE_W          = 20;
	localparam int CONV_W          = 8;

	// frame layout
	localparam int CMD_BITS = 20;
	localparam int RES_BITS = 16;
	localparam int TX_BITS  = 32;
	localparam int OP_MSB   = 19;
	localparam int OP_LSB   = 16;
	localparam int ADDR_MSB = 15;
	localparam int ADDR_LSB = 8;
	localparam int DATA_MSB = 7;

	localparam logic [4:0] CMD_CNT_FULL = 5'h14;
	localparam logic [5:0] DUAL_LAST    = 6'h10;
	localparam logic [5:0] SINGLE_LAST  = 6'h20;

	// opcodes
	localparam logic [3:0] OP_NOP   = 4'h0;
	localparam logic [3:0] OP_WRITE = 4'h1;
	localparam logic [3:0] OP_READ  = 4'h2;
	localparam logic [3:0] OP_SET   = 4'h3;
	localparam logic [3:0] OP_CLEAR = 4'h4;

	localparam logic [3:0] UNLOCK_CODE = 4'h9;

	// register file
	localparam int REG_COUNT     = 10;
	localparam int IDX_PWR       = 0;
	localparam int IDX_KEY       = 1;
	localparam int IDX_LANE      = 2;
	localparam int IDX_FMT       = 3;
	localparam int IDX_REFSEL    = 4;
	localparam int IDX_TRIM_A_LO = 5;
	localparam int IDX_TRIM_A_HI = 6;
	localparam int IDX_TRIM_B_LO = 7;
	localparam int IDX_TRIM_B_HI = 8;
	localparam int IDX_INCFG     = 9;

	localparam logic [7:0] REG_OFFSET [REG_COUNT] = '{8'h04, 8'h05, 8'h0D, 8'h11, 8'h20,
		8'h24, 8'h25, 8'h26, 8'h27, 8'h28};
	localparam logic [7:0] REG_MASK [REG_COUNT] = '{8'h06, 8'h0F, 8'h01, 8'h01, 8'hFF,
		8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
	localparam logic [7:0] REG_RESET = 8'h00;

	localparam int STANDBY_BIT = 2;
	localparam int PD_BIT      = 1;
	localparam int LANE_BIT    = 0;
	localparam int FMT_BIT     = 0;
	localparam int REF_INT_BIT = 0;

	typedef enum logic [3:0] {
		PWR_RUN  = 4'b0001,
		PWR_STBY = 4'b0010,
		PWR_DOWN = 4'b0100,
		PWR_WAKE = 4'b1000
	} dahp_pwr_type;

endpackage : dahp_pkg

// ===== design/dahp_link_if.sv
// signals between the serial-clock side and the system-clock side
`timescale 1ns/1ps
`default_nettype none
interface dahp_link_if;
	logic [dahp_pkg::CMD_BITS-1:0] cmd_word;
	logic                          cmd_full;
	logic [dahp_pkg::TX_BITS-1:0]  tx_word;
	logic                          single_lane;

	modport link (output cmd_word, output cmd_full, input tx_word, input single_lane);
	modport core (input cmd_word, input cmd_full, output tx_word, output single_lane);
endinterface : dahp_link_if
`default_nettype wire

// ===== design/dahp_link.sv
// serial-clock side: command shifter and result serialiser
`timescale 1ns/1ps
`default_nettype none
module dahp_link (
	input  wire logic    sclk,
	input  wire logic    cs_n,
	input  wire logic    arst_n,
	input  wire logic    sdi,
	dahp_link_if.link    lnk,
	output logic         lane_a,
	output logic         lane_a_oe,
	output logic         lane_b,
	output logic         lane_b_oe
);
	logic                          frame_rst;
	logic                          first_reg;
	logic [dahp_pkg::CMD_BITS-1:0] shift_reg;
	logic [dahp_pkg::CMD_BITS-1:0] shift_next;
	logic [4:0]                    cnt_reg;
	logic [4:0]                    cnt_next;
	logic [5:0]                    fall_reg;
	logic [4:0]                    idx_a;
	logic [3:0]                    idx_d;
	logic                          dual_a;
	logic                          dual_b;
	logic                          single_a;

	assign frame_rst = cs_n | ~arst_n;

	// the serial clock stands still between frames, so the frame start is held
	// asynchronously while chip select is high and consumed by the first edge
	always_ff @(posedge sclk or posedge frame_rst) begin
		if (frame_rst)
			first_reg <= 1'b1;
		else
			first_reg <= 1'b0;
	end

	// only the last twenty bits survive; the count saturates at twenty
	assign shift_next = {shift_reg[dahp_pkg::CMD_BITS-2:0], sdi};
	assign cnt_next   = first_reg ? 5'h01 :
		(cnt_reg == dahp_pkg::CMD_CNT_FULL) ? cnt_reg : cnt_reg + 5'h01;

	// data in is taken on the rising edge, opposite to the output edge
	always_ff @(posedge sclk or negedge arst_n) begin
		if (!arst_n) begin
			shift_reg <= '0;
			cnt_reg   <= 5'h00;
		end else begin
			shift_reg <= shift_next;
			cnt_reg   <= cnt_next;
		end
	end

	assign lnk.cmd_word = shift_reg;
	assign lnk.cmd_full = (cnt_reg == dahp_pkg::CMD_CNT_FULL);

	// falling edges seen in this frame; zero while chip select is high
	always_ff @(negedge sclk or posedge frame_rst) begin
		if (frame_rst)
			fall_reg <= 6'h00;
		else if (fall_reg != dahp_pkg::SINGLE_LAST)
			fall_reg <= fall_reg + 6'h01;
	end

	assign idx_a    = 5'h1F - fall_reg[4:0];
	assign idx_d    = 4'hF - fall_reg[3:0];
	assign dual_a   = (fall_reg < dahp_pkg::DUAL_LAST) & lnk.tx_word[{1'b1, idx_d}];
	assign dual_b   = (fall_reg < dahp_pkg::DUAL_LAST) & lnk.tx_word[{1'b0, idx_d}];
	assign single_a = (fall_reg < dahp_pkg::SINGLE_LAST) & lnk.tx_word[idx_a];

	// msb shows as soon as chip select falls, hence no output flop here
	assign lane_a    = lnk.single_lane ? single_a : dual_a;
	assign lane_b    = lnk.single_lane ? 1'b0 : dual_b;
	assign lane_a_oe = ~cs_n;
	assign lane_b_oe = ~cs_n;

endmodule : dahp_link
`default_nettype wire

// ===== design/dahp_top.sv
// serial host port of a dual simultaneous-sampling converter
// Function
// - dual-lane mode: lane a carries converter a, lane b converter b, together
// - chip select rising floats outputs, samples inputs, starts timed conversion
// - chip select falling drives outputs and shows the msb at once
// - each lower bit follows on the next serial clock falling edge
// - dual-lane: both lanes low after sixteenth falling edge until frame end
// - single-lane: lane a sends a then b, b from sixteenth falling edge
// - single-lane: lane a low after thirty-second falling edge until frame end
// - single-lane: lane b driven low while the interface is active
// - normal mode keeps converters and oscillator powered so any frame end converts
// - standby powers off converters and oscillator, keeps reference and trims
// - standby changes only after the unlock key was written
// - leaving standby takes ten microseconds before normal operation
// - full power-down keeps only interface alive, also needs the key
// - leaving power-down takes one or three milliseconds by reference source
// - top four bits are opcode, then address byte, then data byte
// - unknown opcodes act as no operation and change nothing
// - after a no operation the next frame carries conversion results
// - set and clear commands touch only bits whose mask bit is one
// - frames right-aligned; short frames dropped, long ones use last twenty
// - write-type commands take effect when chip select rises
// - a read returns the register byte first on lane a next frame
// - power control register writable only after key field holds 1001
`timescale 1ns/1ps
`default_nettype none
module dahp_top #(
	parameter int PD_WAKE_EXT_CYCLES = dahp_pkg::PD_WAKE_EXT_CYC,
	parameter int PD_WAKE_INT_CYCLES = dahp_pkg::PD_WAKE_INT_CYC
) (
	input  wire logic                           CLK,
	input  wire logic                           ARST_N,
	input  wire logic                           LINK_SCLK,
	input  wire logic                           CHIP_SELECT_N,
	input  wire logic                           SERIAL_DATA_IN,
	input  wire logic [dahp_pkg::RES_BITS-1:0]  ADC_A_CODE,
	input  wire logic [dahp_pkg::RES_BITS-1:0]  ADC_B_CODE,
	output logic                                DATA_OUT_LANE_A,
	output logic                                DATA_OUT_LANE_A_OE,
	output logic                                DATA_OUT_LANE_B,
	output logic                                DATA_OUT_LANE_B_OE,
	output logic                                CONVERTING,
	output logic                                ADC_POWER_ON,
	output logic                                OSC_POWER_ON,
	output logic                                REF_POWER_ON,
	output logic                                POWER_READY,
	output logic                                OUTPUT_LANE_SELECT,
	output logic                                TWOS_COMPLEMENT,
	output logic [7:0]                          REF_SELECT,
	output logic [7:0]                          INPUT_CONFIG,
	output logic [15:0]                         REF_TRIM_A,
	output logic [15:0]                         REF_TRIM_B
);
	dahp_link_if lnk ();

	logic                          cs_s1_reg;
	logic                          cs_s2_reg;
	logic                          cs_d_reg;
	logic                          cs_rise;
	logic                          frame_ok;
	logic [3:0]                    cmd_op;
	logic [7:0]                    cmd_addr;
	logic [7:0]                    cmd_data;
	logic                          op_write_type;
	logic                          wr_cmd;
	logic                          rd_cmd;
	logic                          key_ok;
	logic [7:0]                    cur_value;
	logic [7:0]                    wr_value;
	logic [dahp_pkg::REG_COUNT-1:0] hit;
	logic [dahp_pkg::REG_COUNT-1:0] wr_ok;
	logic [7:0]                    regs_reg [dahp_pkg::REG_COUNT];
	logic                          rd_hold_reg;
	logic [dahp_pkg::TX_BITS-1:0]  tx_reg;
	logic [dahp_pkg::RES_BITS-1:0] samp_a_reg;
	logic [dahp_pkg::RES_BITS-1:0] samp_b_reg;
	logic [dahp_pkg::RES_BITS-1:0] res_a;
	logic [dahp_pkg::RES_BITS-1:0] res_b;
	logic [dahp_pkg::CONV_W-1:0]   conv_cnt_reg;
	logic [dahp_pkg::CONV_W-1:0]   conv_cnt_next;
	logic                          conv_start;
	logic                          conv_done;
	logic                          standby_bit;
	logic                          pd_bit;
	logic                          ref_internal;
	dahp_pkg::dahp_pwr_type        pwr_reg;
	dahp_pkg::dahp_pwr_type        pwr_next;
	logic [dahp_pkg::WAKE_W-1:0]   wake_cnt_reg;
	logic [dahp_pkg::WAKE_W-1:0]   wake_cnt_next;
	logic [dahp_pkg::WAKE_W-1:0]   wake_load;
	logic                          wake_start;
	logic                          adc_on_reg;
	logic                          ref_on_reg;
	logic                          ready_reg;
	logic                          conv_busy_reg;

	dahp_link u_link (
		.sclk      (LINK_SCLK),
		.cs_n      (CHIP_SELECT_N),
		.arst_n    (ARST_N),
		.sdi       (SERIAL_DATA_IN),
		.lnk       (lnk.link),
		.lane_a    (DATA_OUT_LANE_A),
		.lane_a_oe (DATA_OUT_LANE_A_OE),
		.lane_b    (DATA_OUT_LANE_B),
		.lane_b_oe (DATA_OUT_LANE_B_OE)
	);

	// chip select crossing; its rising edge is the handshake for the command word
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			cs_s1_reg <= 1'b1;
			cs_s2_reg <= 1'b1;
			cs_d_reg  <= 1'b1;
		end else begin
			cs_s1_reg <= CHIP_SELECT_N;
			cs_s2_reg <= cs_s1_reg;
			cs_d_reg  <= cs_s2_reg;
		end
	end

	assign cs_rise = cs_s2_reg & ~cs_d_reg;

	// the shifter is quiet here because the serial clock stays high after the frame
	assign frame_ok = cs_rise & lnk.cmd_full;

	assign cmd_op   = lnk.cmd_word[dahp_pkg::OP_MSB:dahp_pkg::OP_LSB];
	assign cmd_addr = lnk.cmd_word[dahp_pkg::ADDR_MSB:dahp_pkg::ADDR_LSB];
	assign cmd_data = lnk.cmd_word[dahp_pkg::DATA_MSB:0];

	// anything other than write, set, clear or read is left without effect
	assign op_write_type = (cmd_op == dahp_pkg::OP_WRITE) | (cmd_op == dahp_pkg::OP_SET) |
		(cmd_op == dahp_pkg::OP_CLEAR);
	assign wr_cmd = frame_ok & op_write_type;
	assign rd_cmd = frame_ok & (cmd_op == dahp_pkg::OP_READ);

	assign key_ok = (regs_reg[dahp_pkg::IDX_KEY][3:0] == dahp_pkg::UNLOCK_CODE);

	always_comb begin
		cur_value = 8'h00;
		for (int k = 0; k < dahp_pkg::REG_COUNT; k++) begin
			if (hit[k])
				cur_value = cur_value | regs_reg[k];
		end
	end

	assign wr_value = (cmd_op == dahp_pkg::OP_WRITE) ? cmd_data :
		(cmd_op == dahp_pkg::OP_SET) ? (cur_value | cmd_data) :
		(cur_value & ~cmd_data);

	// unmapped addresses are ignored on write and read back as zero
	for (genvar i = 0; i < dahp_pkg::REG_COUNT; i++) begin : g_reg
		assign hit[i] = (cmd_addr == dahp_pkg::REG_OFFSET[i]);
		assign wr_ok[i] = wr_cmd & hit[i] & ((i != dahp_pkg::IDX_PWR) | key_ok);
		always_ff @(posedge CLK or negedge ARST_N) begin
			if (!ARST_N)
				regs_reg[i] <= dahp_pkg::REG_RESET;
			else if (wr_ok[i])
				regs_reg[i] <= wr_value & dahp_pkg::REG_MASK[i];
		end
	end

	assign standby_bit  = regs_reg[dahp_pkg::IDX_PWR][dahp_pkg::STANDBY_BIT];
	assign pd_bit       = regs_reg[dahp_pkg::IDX_PWR][dahp_pkg::PD_BIT];
	assign ref_internal = regs_reg[dahp_pkg::IDX_REFSEL][dahp_pkg::REF_INT_BIT];

	// conversion: started only when the converters are powered
	assign conv_start = cs_rise & (pwr_reg == dahp_pkg::PWR_RUN);
	assign conv_done  = (conv_cnt_reg == dahp_pkg::CONV_W'(1));
	assign conv_cnt_next = conv_start ? dahp_pkg::CONV_W'(dahp_pkg::CONV_CYC) :
		(conv_cnt_reg != '0) ? conv_cnt_reg - dahp_pkg::CONV_W'(1) : conv_cnt_reg;

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			conv_cnt_reg  <= '0;
			conv_busy_reg <= 1'b0;
			samp_a_reg    <= '0;
			samp_b_reg    <= '0;
		end else begin
			conv_cnt_reg  <= conv_cnt_next;
			conv_busy_reg <= (conv_cnt_next != '0);
			if (conv_start) begin
				samp_a_reg <= ADC_A_CODE;
				samp_b_reg <= ADC_B_CODE;
			end
		end
	end

	// two's complement output only flips the msb of the straight code
	assign res_a = samp_a_reg ^ {regs_reg[dahp_pkg::IDX_FMT][dahp_pkg::FMT_BIT], 15'h0000};
	assign res_b = samp_b_reg ^ {regs_reg[dahp_pkg::IDX_FMT][dahp_pkg::FMT_BIT], 15'h0000};

	// a read frame parks the register byte for exactly the following frame
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rd_hold_reg <= 1'b0;
			tx_reg      <= 32'h0000_0000;
		end else begin
			if (cs_rise)
				rd_hold_reg <= rd_cmd;
			if (rd_cmd)
				tx_reg <= {cur_value, 24'h00_0000};
			else if (conv_done & ~rd_hold_reg)
				tx_reg <= {res_a, res_b};
		end
	end

	// both words change only between frames, so the link side sees them stable
	assign lnk.tx_word     = tx_reg;
	assign lnk.single_lane = regs_reg[dahp_pkg::IDX_LANE][dahp_pkg::LANE_BIT];

	// power sequencing
	always_comb begin
		pwr_next   = pwr_reg;
		wake_start = 1'b0;
		wake_load  = dahp_pkg::WAKE_W'(dahp_pkg::STBY_WAKE_CYC);
		case (pwr_reg)
			dahp_pkg::PWR_RUN: begin
				if (pd_bit)
					pwr_next = dahp_pkg::PWR_DOWN;
				else if (standby_bit)
					pwr_next = dahp_pkg::PWR_STBY;
			end
			dahp_pkg::PWR_STBY: begin
				if (pd_bit)
					pwr_next = dahp_pkg::PWR_DOWN;
				else if (!standby_bit) begin
					pwr_next   = dahp_pkg::PWR_WAKE;
					wake_start = 1'b1;
					wake_load  = dahp_pkg::WAKE_W'(dahp_pkg::STBY_WAKE_CYC);
				end
			end
			dahp_pkg::PWR_DOWN: begin
				if (!pd_bit) begin
					pwr_next   = standby_bit ? dahp_pkg::PWR_STBY : dahp_pkg::PWR_WAKE;
					wake_start = ~standby_bit;
					wake_load  = ref_internal ? dahp_pkg::WAKE_W'(PD_WAKE_INT_CYCLES) :
						dahp_pkg::WAKE_W'(PD_WAKE_EXT_CYCLES);
				end
			end
			dahp_pkg::PWR_WAKE: begin
				if (pd_bit)
					pwr_next = dahp_pkg::PWR_DOWN;
				else if (standby_bit)
					pwr_next = dahp_pkg::PWR_STBY;
				else if (wake_cnt_reg == dahp_pkg::WAKE_W'(1))
					pwr_next = dahp_pkg::PWR_RUN;
			end
			default: pwr_next = dahp_pkg::PWR_RUN;
		endcase
	end

	assign wake_cnt_next = wake_start ? wake_load :
		(wake_cnt_reg != '0) ? wake_cnt_reg - dahp_pkg::WAKE_W'(1) : wake_cnt_reg;

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			pwr_reg      <= dahp_pkg::PWR_RUN;
			wake_cnt_reg <= '0;
		end else begin
			pwr_reg      <= pwr_next;
			wake_cnt_reg <= wake_cnt_next;
		end
	end

	// power outputs registered from the next state so they track it exactly
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			adc_on_reg <= 1'b1;
			ref_on_reg <= 1'b0;
			ready_reg  <= 1'b1;
		end else begin
			adc_on_reg <= (pwr_next == dahp_pkg::PWR_RUN) |
				(pwr_next == dahp_pkg::PWR_WAKE);
			ref_on_reg <= (pwr_next != dahp_pkg::PWR_DOWN) & ref_internal;
			ready_reg  <= (pwr_next == dahp_pkg::PWR_RUN);
		end
	end

	assign ADC_POWER_ON       = adc_on_reg;
	assign OSC_POWER_ON       = adc_on_reg;
	assign REF_POWER_ON       = ref_on_reg;
	assign POWER_READY        = ready_reg;
	assign CONVERTING         = conv_busy_reg;
	assign OUTPUT_LANE_SELECT = regs_reg[dahp_pkg::IDX_LANE][dahp_pkg::LANE_BIT];
	assign TWOS_COMPLEMENT    = regs_reg[dahp_pkg::IDX_FMT][dahp_pkg::FMT_BIT];
	assign REF_SELECT         = regs_reg[dahp_pkg::IDX_REFSEL];
	assign INPUT_CONFIG       = regs_reg[dahp_pkg::IDX_INCFG];
	// trims are never touched by the power states, so they survive standby
	assign REF_TRIM_A         = {regs_reg[dahp_pkg::IDX_TRIM_A_HI],
		regs_reg[dahp_pkg::IDX_TRIM_A_LO]};
	assign REF_TRIM_B         = {regs_reg[dahp_pkg::IDX_TRIM_B_HI],
		regs_reg[dahp_pkg::IDX_TRIM_B_LO]};

endmodule : dahp_top
`default_nettype wire

// ===== bench/dahp_top_sva.sv
// pin-level assertions for the dual converter serial host port
`timescale 1ns/1ps
`default_nettype none
module dahp_top_sva (
	input wire logic       CLK,
	input wire logic       ARST_N,
	input wire logic       LINK_SCLK,
	input wire logic       CHIP_SELECT_N,
	input wire logic       DATA_OUT_LANE_A,
	input wire logic       DATA_OUT_LANE_A_OE,
	input wire logic       DATA_OUT_LANE_B,
	input wire logic       DATA_OUT_LANE_B_OE,
	input wire logic       CONVERTING,
	input wire logic       ADC_POWER_ON,
	input wire logic       OSC_POWER_ON,
	input wire logic       REF_POWER_ON,
	input wire logic       POWER_READY,
	input wire logic       OUTPUT_LANE_SELECT,
	input wire logic [7:0] REF_SELECT
);
	localparam logic [7:0] CONV_LEN = 8'(dahp_pkg::CONV_CYC);
	logic [7:0] conv_cnt_reg;
	logic [5:0] fall_cnt_reg;
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) conv_cnt_reg <= 8'h00;
		else conv_cnt_reg <= CONVERTING ? conv_cnt_reg + 8'h01 : 8'h00;
	end
	// falls within a frame; saturates so long frames cannot wrap back to low counts
	always_ff @(negedge LINK_SCLK or posedge CHIP_SELECT_N) begin
		if (CHIP_SELECT_N) fall_cnt_reg <= 6'h00;
		else if (fall_cnt_reg != 6'h3F) fall_cnt_reg <= fall_cnt_reg + 6'h01;
	end
	a_oe_a_follows:
		assert property (@(posedge CLK) disable iff (!ARST_N) DATA_OUT_LANE_A_OE == !CHIP_SELECT_N)
		else $error("lane a enable does not follow select");
	a_oe_b_follows:
		assert property (@(posedge CLK) disable iff (!ARST_N) DATA_OUT_LANE_B_OE == !CHIP_SELECT_N)
		else $error("lane b enable does not follow select");
	a_dual_tail_low:
		assert property (@(posedge LINK_SCLK) disable iff (!ARST_N || CHIP_SELECT_N)
			fall_cnt_reg >= 6'h10 && !OUTPUT_LANE_SELECT |-> !DATA_OUT_LANE_A && !DATA_OUT_LANE_B)
		else $error("dual lane tail not low");
	a_single_tail_low:
		assert property (@(posedge LINK_SCLK) disable iff (!ARST_N || CHIP_SELECT_N)
			fall_cnt_reg >= 6'h20 && OUTPUT_LANE_SELECT |-> !DATA_OUT_LANE_A)
		else $error("single lane tail not low");
	a_single_b_low:
		assert property (@(posedge LINK_SCLK) disable iff (!ARST_N || CHIP_SELECT_N)
			OUTPUT_LANE_SELECT |-> !DATA_OUT_LANE_B) else $error("lane b not low in single mode");
	a_conv_length:
		assert property (@(posedge CLK) disable iff (!ARST_N) $fell(CONVERTING) |-> conv_cnt_reg == CONV_LEN)
		else $error("conversion length wrong");
	a_conv_starts:
		assert property (@(posedge CLK) disable iff (!ARST_N) $rose(CHIP_SELECT_N) && POWER_READY
			|-> ##[1:6] (CONVERTING || !POWER_READY)) else $error("no conversion after frame");
	a_power_pair:
		assert property (@(posedge CLK) disable iff (!ARST_N) ADC_POWER_ON == OSC_POWER_ON)
		else $error("converter and oscillator power differ");
	a_ready_powered:
		assert property (@(posedge CLK) disable iff (!ARST_N) POWER_READY |-> ADC_POWER_ON)
		else $error("ready while converters off");
	a_ref_power:
		assert property (@(posedge CLK) disable iff (!ARST_N)
			REF_POWER_ON |-> REF_SELECT[0] || $past(REF_SELECT[0])) else $error("reference on unselected");
endmodule : dahp_top_sva
bind dahp_top dahp_top_sva u_dahp_top_sva (
	.CLK(CLK), .ARST_N(ARST_N), .LINK_SCLK(LINK_SCLK), .CHIP_SELECT_N(CHIP_SELECT_N),
	.DATA_OUT_LANE_A(DATA_OUT_LANE_A), .DATA_OUT_LANE_A_OE(DATA_OUT_LANE_A_OE),
	.DATA_OUT_LANE_B(DATA_OUT_LANE_B), .DATA_OUT_LANE_B_OE(DATA_OUT_LANE_B_OE),
	.CONVERTING(CONVERTING), .ADC_POWER_ON(ADC_POWER_ON), .OSC_POWER_ON(OSC_POWER_ON),
	.REF_POWER_ON(REF_POWER_ON), .POWER_READY(POWER_READY),
	.OUTPUT_LANE_SELECT(OUTPUT_LANE_SELECT), .REF_SELECT(REF_SELECT)
);
`default_nettype wire

// ===== bench/dahp_host_model.sv
// host controller model: sends frames msb first and captures both lanes
`timescale 1ns/1ps
`default_nettype none
module dahp_host_model (
	output logic      sclk,
	output logic      cs_n,
	output logic      sdi,
	input  wire logic lane_a,
	input  wire logic lane_a_oe,
	input  wire logic lane_b,
	input  wire logic lane_b_oe
);
	logic        hold_a;
	logic        hold_b;
	logic [63:0] cap_a;
	logic [63:0] cap_b;
	// a released lane reads as the inverse of its last value, so stale data cannot match
	always @* if (lane_a_oe) hold_a = lane_a;
	always @* if (lane_b_oe) hold_b = lane_b;
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		sdi  = 1'b0;
	end
	task automatic frame(input int n, input logic [63:0] w);
		#3.3 cs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			#40 cap_a = {cap_a[62:0], lane_a_oe ? lane_a : ~hold_a};
			cap_b = {cap_b[62:0], lane_b_oe ? lane_b : ~hold_b};
			sclk = 1'b0;
			sdi  = w[n-1-i];
			#40 sclk = 1'b1;
		end
		#40 cs_n = 1'b1;
		sdi = ~sdi;
		#800;
	endtask : frame
endmodule : dahp_host_model
`default_nettype wire

// ===== bench/dahp_top_test.sv
// self-checking bench for the dual converter serial host port
`timescale 1ns/1ps
`default_nettype none
module dahp_top_test;
	logic        clk;
	logic        arst_n;
	logic [15:0] code_a;
	logic [15:0] code_b;
	wire  logic  sclk, cs_n, sdi, la, la_oe, lb, lb_oe;
	wire  logic  conv, adc_on, osc_on, ref_on, ready, lane_sel, twos;
	wire  logic [7:0]  ref_sel, in_cfg;
	wire  logic [15:0] trim_a, trim_b;
	int          err_count = 0;
	int          num_checks = 0;
	int          cyc = 0;
	dahp_top #(.PD_WAKE_EXT_CYCLES(40), .PD_WAKE_INT_CYCLES(120)) u_dahp_top (
		.CLK(clk), .ARST_N(arst_n), .LINK_SCLK(sclk), .CHIP_SELECT_N(cs_n),
		.SERIAL_DATA_IN(sdi), .ADC_A_CODE(code_a), .ADC_B_CODE(code_b),
		.DATA_OUT_LANE_A(la), .DATA_OUT_LANE_A_OE(la_oe), .DATA_OUT_LANE_B(lb),
		.DATA_OUT_LANE_B_OE(lb_oe), .CONVERTING(conv), .ADC_POWER_ON(adc_on),
		.OSC_POWER_ON(osc_on), .REF_POWER_ON(ref_on), .POWER_READY(ready),
		.OUTPUT_LANE_SELECT(lane_sel), .TWOS_COMPLEMENT(twos), .REF_SELECT(ref_sel),
		.INPUT_CONFIG(in_cfg), .REF_TRIM_A(trim_a), .REF_TRIM_B(trim_b)
	);
	dahp_host_model u_dahp_host_model (
		.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .lane_a(la), .lane_a_oe(la_oe),
		.lane_b(lb), .lane_b_oe(lb_oe)
	);
	initial clk = 1'b0;
	always #5 clk = ~clk;
	task automatic test_done();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : test_done
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			err_count++;
			test_done();
		end
	end
	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic frm(input int n, input logic [63:0] w);
		u_dahp_host_model.frame(n, w);
	endtask : frm
	task automatic cmd(input logic [3:0] op, input logic [7:0] ad, input logic [7:0] d);
		frm(20, {44'h0, op, ad, d});
	endtask : cmd
	initial begin
		arst_n = 1'b0;
		code_a = 16'hA5C3;
		code_b = 16'h3C5A;
		repeat (20) @(posedge clk);
		@(negedge clk) arst_n = 1'b1;
		chk("ready", 1, ready);
		chk("ref_sel", 0, ref_sel);
		chk("lane_sel", 0, lane_sel);
		// first nop converts, the following frame carries both codes
		cmd(4'h0, 8'h00, 8'h00);
		frm(20, 64'h0);
		chk("dual_a", {code_a, 4'h0}, u_dahp_host_model.cap_a[19:0]);
		chk("dual_b", {code_b, 4'h0}, u_dahp_host_model.cap_b[19:0]);
		cmd(4'h1, 8'h20, 8'h5B);
		chk("write", 8'h5B, ref_sel);
		cmd(4'h3, 8'h20, 8'h80);
		chk("set", 8'hDB, ref_sel);
		cmd(4'h4, 8'h20, 8'h0A);
		chk("clear", 8'hD1, ref_sel);
		for (int op = 5; op < 16; op++) begin
			cmd(op[3:0], 8'h20, 8'h00);
			chk("reserved_op", 8'hD1, ref_sel);
		end
		frm(19, {44'h0, 4'h1, 8'h20, 8'h00});
		chk("short", 8'hD1, ref_sel);
		frm(24, {40'h0, 4'hF, 4'h1, 8'h28, 8'h3C});
		chk("long", 8'h3C, in_cfg);
		cmd(4'h2, 8'h28, 8'h00);
		frm(20, 64'h0);
		chk("read", 8'h3C, u_dahp_host_model.cap_a[19:12]);
		cmd(4'h1, 8'h24, 8'h34);
		cmd(4'h1, 8'h25, 8'h12);
		cmd(4'h1, 8'h27, 8'h56);
		chk("trim_b", 16'h5600, trim_b);
		cmd(4'h1, 8'h0D, 8'h01);
		chk("lane_sel", 1, lane_sel);
		cmd(4'h0, 8'h00, 8'h00);
		frm(34, 64'h0);
		chk("single_a", {code_a, code_b, 2'b00}, u_dahp_host_model.cap_a[33:0]);
		chk("single_b", 0, u_dahp_host_model.cap_b[33:0]);
		cmd(4'h1, 8'h0D, 8'h00);
		// the format write frame also converts, so the next frame already shows flipped msbs
		cmd(4'h1, 8'h11, 8'h01);
		chk("twos", 1, twos);
		cmd(4'h0, 8'h00, 8'h00);
		chk("twos_a", {code_a ^ 16'h8000, 4'h0}, u_dahp_host_model.cap_a[19:0]);
		chk("twos_b", {code_b ^ 16'h8000, 4'h0}, u_dahp_host_model.cap_b[19:0]);
		cmd(4'h1, 8'h04, 8'h04);
		chk("locked", 1, ready);
		cmd(4'h1, 8'h05, 8'h09);
		cmd(4'h1, 8'h04, 8'h04);
		chk("stby_adc", 0, adc_on);
		chk("stby_osc", 0, osc_on);
		chk("stby_ref", 1, ref_on);
		chk("stby_trim", 16'h1234, trim_a);
		cmd(4'h1, 8'h04, 8'h00);
		repeat (dahp_pkg::STBY_WAKE_CYC - 150) @(negedge clk);
		chk("stby_wake", 0, ready);
		repeat (100) @(negedge clk);
		chk("stby_up", 1, ready);
		cmd(4'h1, 8'h04, 8'h02);
		chk("pd_ref", 0, ref_on);
		chk("pd_adc", 0, adc_on);
		cmd(4'h1, 8'h04, 8'h00);
		repeat (20) @(negedge clk);
		chk("pd_wake", 0, ready);
		repeat (40) @(negedge clk);
		chk("pd_up", 1, ready);
		test_done();
	end
endmodule : dahp_top_test
`default_nettype wire
